// *** hw/ioc_params.svh ***
// Constants for the I/O cell: timing counts, register offsets, resets.
// Assumes the system clock runs at 100 MHz.
`ifndef IOC_PARAMS_SVH
`define IOC_PARAMS_SVH

`define IOC_CLK_NS       10
`define IOC_DLY_FULL_NS  30
`define IOC_DLY_MED_NS   20
`define IOC_DLY_FULL_CYC \
	((`IOC_DLY_FULL_NS + `IOC_CLK_NS - 1) / `IOC_CLK_NS)
`define IOC_DLY_MED_CYC \
	((`IOC_DLY_MED_NS + `IOC_CLK_NS - 1) / `IOC_CLK_NS)

`define IOC_OFS_CTRL     4'h0
`define IOC_OFS_STAT     4'h4
`define IOC_CTRL_W       17
`define IOC_STAT_W       9
`define IOC_CTRL_RST     17'h00000
`define IOC_RESP_OKAY    2'b00
`define IOC_RESP_SLVERR  2'b10

`endif

// *** hw/ioc_pkg.sv ***
// Types shared by the I/O cell design.
// Assumes ioc_params.svh fixes the register widths.
`default_nettype none
`include "ioc_params.svh"

package ioc_pkg;

	typedef enum logic [1:0]
	{
		IOC_DLY_AUTO = 2'b00,
		IOC_DLY_MED  = 2'b01,
		IOC_DLY_NONE = 2'b10,
		IOC_DLY_FULL = 2'b11
	} ioc_dly_t;

	typedef enum logic [1:0]
	{
		IOC_SEL_CTRL = 2'b00,
		IOC_SEL_STAT = 2'b01,
		IOC_SEL_NONE = 2'b10
	} ioc_sel_t;

	typedef struct packed {
		logic     fab2_reg;
		logic     fab1_reg;
		logic     quick_en;
		ioc_dly_t dly_sel;
		logic     t_conn;
		logic     ce_conn;
		logic     ce_out_en;
		logic     ce_in_en;
		logic     t_inv;
		logic     out_inv;
		logic     out_reg;
		logic     out_preset;
		logic     in_preset;
		logic     out_clk_inv;
		logic     in_clk_inv;
		logic     in_latch;
	} ioc_cfg_t;

	typedef struct packed {
		ioc_dly_t dly_eff;
		logic     out_clk_lvl;
		logic     in_clk_lvl;
		logic     pad_driven;
		logic     pad_lvl;
		logic     quick_q;
		logic     out_q;
		logic     in_q;
	} ioc_stat_t;

endpackage : ioc_pkg

`default_nettype wire

// *** hw/ioc_cell.sv ***
// One programmable I/O cell: input register, input delay, quick capture
// latch, output flop and three-state control, set up over AXI4-Lite.
// Assumes pad and cell clock pins are asynchronous to sys_clk; fabric
// signals are synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
`include "ioc_params.svh"

module ioc_cell
	import ioc_pkg::*;
#(
	parameter int ADDR_W   = 4,
	parameter int TWO_TAP  = 1,
	parameter int DLY_FULL = `IOC_DLY_FULL_CYC,
	parameter int DLY_MED  = `IOC_DLY_MED_CYC
)
(
	input  wire logic              sys_clk,
	input  wire logic              resetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output var  logic              s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output var  logic              s_axi_wready,
	output var  logic [1:0]        s_axi_bresp,
	output var  logic              s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output var  logic              s_axi_arready,
	output var  logic [31:0]       s_axi_rdata,
	output var  logic [1:0]        s_axi_rresp,
	output var  logic              s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              pad_in,
	output var  logic              pad_out,
	output var  logic              pad_oe_n,
	input  wire logic              in_clk_pin,
	input  wire logic              out_clk_pin,
	input  wire logic              cell_clock_enable,
	input  wire logic              global_set_reset,
	input  wire logic              global_output_float,
	input  wire logic              extest_active,
	input  wire logic              fab_out_data,
	input  wire logic              fab_tristate,
	output var  logic              fab_in1,
	output var  logic              fab_in2
);

	localparam int TAP_W = $clog2(DLY_FULL + 1);

	// Medium tap must sit strictly inside the full delay line
	if (ADDR_W < 4 || DLY_FULL < 1 || DLY_MED < 1 ||
		DLY_MED >= DLY_FULL || TWO_TAP < 0 || TWO_TAP > 1)
	begin : g_bad_param
		$error("ioc_cell: unsupported parameter values");
	end

	function automatic ioc_sel_t reg_sel(input logic [ADDR_W-1:0] a);
		reg_sel = IOC_SEL_NONE;
		if ((a >> 4) == '0 && a[3:0] == `IOC_OFS_CTRL)
			reg_sel = IOC_SEL_CTRL;
		else if ((a >> 4) == '0 && a[3:0] == `IOC_OFS_STAT)
			reg_sel = IOC_SEL_STAT;
	endfunction : reg_sel

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: a change counts once stages two and three agree

	logic [2:0] pin_in;
	logic [2:0] sync_reg [3];
	logic [2:0] pin_lvl_reg;

	assign pin_in = {out_clk_pin, in_clk_pin, pad_in};

	for (genvar i = 0; i < 3; i++)
	begin : g_sync
		always_ff @(posedge sys_clk)
		begin
			if (!resetn)
			begin
				sync_reg[i]    <= 3'h0;
				pin_lvl_reg[i] <= 1'b0;
			end
			else
			begin
				sync_reg[i] <= {sync_reg[i][1:0], pin_in[i]};
				if (sync_reg[i][1] == sync_reg[i][2])
					pin_lvl_reg[i] <= sync_reg[i][2];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration and derived controls

	logic [`IOC_CTRL_W-1:0] ctrl_reg;
	ioc_cfg_t               cfg;
	ioc_dly_t               dly_eff;
	logic [TAP_W-1:0]       tap;
	logic                   ce_lvl;
	logic                   ce_in;
	logic                   ce_out;
	logic                   in_eff;
	logic                   out_eff;
	logic                   in_prev_reg;
	logic                   out_prev_reg;
	logic                   in_edge;
	logic                   out_edge;

	assign cfg = ioc_cfg_t'(ctrl_reg);

	always_comb
	begin
		case (cfg.dly_sel)
			IOC_DLY_AUTO: dly_eff = (cfg.quick_en && TWO_TAP == 1) ?
				IOC_DLY_MED : IOC_DLY_FULL;
			IOC_DLY_MED:  dly_eff = (TWO_TAP == 1) ?
				IOC_DLY_MED : IOC_DLY_FULL;
			IOC_DLY_NONE: dly_eff = IOC_DLY_NONE;
			default:      dly_eff = IOC_DLY_FULL;
		endcase
		case (dly_eff)
			IOC_DLY_MED:  tap = TAP_W'(DLY_MED);
			IOC_DLY_NONE: tap = '0;
			default:      tap = TAP_W'(DLY_FULL);
		endcase
	end

	// Shared enable; cannot be inverted, only steered per element
	assign ce_lvl = cfg.ce_conn ? cell_clock_enable : 1'b1;
	assign ce_in  = cfg.ce_in_en ? ce_lvl : 1'b1;
	assign ce_out = cfg.ce_out_en ? ce_lvl : 1'b1;

	// Separate clocks, each invertible inside the cell
	assign in_eff   = pin_lvl_reg[1] ^ cfg.in_clk_inv;
	assign out_eff  = pin_lvl_reg[2] ^ cfg.out_clk_inv;
	assign in_edge  = in_eff & ~in_prev_reg;
	assign out_edge = out_eff & ~out_prev_reg;

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			in_prev_reg  <= 1'b0;
			out_prev_reg <= 1'b0;
		end
		else
		begin
			in_prev_reg  <= in_eff;
			out_prev_reg <= out_eff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Input delay line, quick latch and input register

	logic [DLY_FULL:0] dly_line;
	logic [DLY_FULL:1] dly_reg;
	logic              dly_data;
	logic              quick_q_reg;
	logic              in_d;
	logic              in_q_reg;

	// Delay stands for several ns of added setup; zero hold is its purpose
	assign dly_line = {dly_reg, pin_lvl_reg[0]};
	assign dly_data = dly_line[tap];

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			dly_reg <= '0;
		else
			dly_reg <= dly_line[DLY_FULL-1:0];
	end

	// User must feed out_clk_pin from an early buffer of the same pad
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			quick_q_reg <= 1'b0;
		else if (global_set_reset)
			quick_q_reg <= cfg.in_preset;
		else if (!out_eff)
			quick_q_reg <= dly_data;
	end

	assign in_d = cfg.quick_en ? quick_q_reg : dly_data;

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			in_q_reg <= 1'b0;
		else if (global_set_reset)
			in_q_reg <= cfg.in_preset;
		else if (ce_in)
		begin
			if (!cfg.in_latch && in_edge)
				in_q_reg <= in_d;
			else if (cfg.in_latch && !in_eff)
				in_q_reg <= in_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output flop, pad drive and fabric inputs

	logic out_d;
	logic out_q_reg;
	logic t_eff;
	logic pad_out_reg;
	logic pad_oe_n_reg;
	logic fab_in1_reg;
	logic fab_in2_reg;

	assign out_d = fab_out_data ^ cfg.out_inv;
	assign t_eff = (cfg.t_conn ? fab_tristate : 1'b0) ^ cfg.t_inv;

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
			out_q_reg <= 1'b0;
		else if (global_set_reset)
			out_q_reg <= cfg.out_preset;
		else if (out_edge && ce_out)
			out_q_reg <= out_d;
	end

	// Floating takes priority over every data path, open drain relies on it
	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			pad_out_reg  <= 1'b0;
			pad_oe_n_reg <= 1'b1;
		end
		else
		begin
			pad_out_reg  <= cfg.out_reg ? out_q_reg : out_d;
			pad_oe_n_reg <= t_eff | (global_output_float &
				~extest_active);
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			fab_in1_reg <= 1'b0;
			fab_in2_reg <= 1'b0;
		end
		else
		begin
			fab_in1_reg <= cfg.fab1_reg ? in_q_reg : pin_lvl_reg[0];
			fab_in2_reg <= cfg.fab2_reg ? in_q_reg : pin_lvl_reg[0];
		end
	end

	assign pad_out  = pad_out_reg;
	assign pad_oe_n = pad_oe_n_reg;
	assign fab_in1  = fab_in1_reg;
	assign fab_in2  = fab_in2_reg;

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave, one write and one read under way at a time

	logic              aw_held_reg;
	logic              w_held_reg;
	logic [ADDR_W-1:0] aw_addr_reg;
	logic [31:0]       w_data_reg;
	logic [3:0]        w_strb_reg;
	logic              awready_reg;
	logic              wready_reg;
	logic              bvalid_reg;
	logic [1:0]        bresp_reg;
	logic              arready_reg;
	logic              rvalid_reg;
	logic [1:0]        rresp_reg;
	logic [31:0]       rdata_reg;
	logic              aw_fire;
	logic              w_fire;
	logic              do_write;
	logic              aw_held_next;
	logic              w_held_next;
	logic              bvalid_next;
	logic              ar_fire;
	logic              rvalid_next;
	logic [31:0]       wmask;
	logic [31:0]       ctrl_next;
	ioc_stat_t         stat;

	assign aw_fire  = s_axi_awvalid & awready_reg;
	assign w_fire   = s_axi_wvalid & wready_reg;
	assign do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
	assign ar_fire  = s_axi_arvalid & arready_reg;

	assign aw_held_next = do_write ? 1'b0 : (aw_held_reg | aw_fire);
	assign w_held_next  = do_write ? 1'b0 : (w_held_reg | w_fire);
	assign bvalid_next  = do_write | (bvalid_reg & ~s_axi_bready);
	assign rvalid_next  = ar_fire | (rvalid_reg & ~s_axi_rready);

	assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
		{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
	assign ctrl_next = ({15'h0000, ctrl_reg} & ~wmask) | (w_data_reg & wmask);

	assign stat = '{dly_eff: dly_eff, out_clk_lvl: pin_lvl_reg[2],
		in_clk_lvl: pin_lvl_reg[1], pad_driven: ~pad_oe_n_reg,
		pad_lvl: pin_lvl_reg[0], quick_q: quick_q_reg,
		out_q: out_q_reg, in_q: in_q_reg};

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			aw_addr_reg <= '0;
			w_data_reg  <= 32'h00000000;
			w_strb_reg  <= 4'h0;
			awready_reg <= 1'b0;
			wready_reg  <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= `IOC_RESP_OKAY;
			ctrl_reg    <= `IOC_CTRL_RST;
		end
		else
		begin
			aw_held_reg <= aw_held_next;
			w_held_reg  <= w_held_next;
			awready_reg <= ~aw_held_next & ~bvalid_next;
			wready_reg  <= ~w_held_next & ~bvalid_next;
			bvalid_reg  <= bvalid_next;
			if (aw_fire)
				aw_addr_reg <= s_axi_awaddr;
			if (w_fire)
			begin
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (do_write)
			begin
				// Status is read only; writes to it are dropped quietly
				bresp_reg <= (reg_sel(aw_addr_reg) == IOC_SEL_NONE) ?
					`IOC_RESP_SLVERR : `IOC_RESP_OKAY;
				if (reg_sel(aw_addr_reg) == IOC_SEL_CTRL)
					ctrl_reg <= ctrl_next[`IOC_CTRL_W-1:0];
			end
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b0;
			rresp_reg   <= `IOC_RESP_OKAY;
			rdata_reg   <= 32'h00000000;
		end
		else
		begin
			arready_reg <= ~rvalid_next;
			rvalid_reg  <= rvalid_next;
			if (ar_fire)
			begin
				case (reg_sel(s_axi_araddr))
					IOC_SEL_CTRL:
					begin
						rdata_reg <= {15'h0000, ctrl_reg};
						rresp_reg <= `IOC_RESP_OKAY;
					end
					IOC_SEL_STAT:
					begin
						rdata_reg <= {23'h000000, stat};
						rresp_reg <= `IOC_RESP_OKAY;
					end
					default:
					begin
						rdata_reg <= 32'h00000000;
						rresp_reg <= `IOC_RESP_SLVERR;
					end
				endcase
			end
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready  = wready_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rresp   = rresp_reg;
	assign s_axi_rdata   = rdata_reg;

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	sequence s_in_loaded;
		!cfg.in_latch && in_edge && ce_in && !global_set_reset;
	endsequence

	sequence s_write_ready;
		aw_held_reg && w_held_reg && !bvalid_reg;
	endsequence

	chk_gsr_preset: assert property (
		global_set_reset |=> in_q_reg == $past(cfg.in_preset) &&
			out_q_reg == $past(cfg.out_preset))
		else $error("storage elements missed preset value");

	chk_in_ff_load: assert property (
		s_in_loaded |=> in_q_reg == $past(in_d))
		else $error("input flop did not load on active edge");

	chk_latch_hold: assert property (
		cfg.in_latch && in_eff && !global_set_reset |=> $stable(in_q_reg))
		else $error("input latch changed while clock high");

	chk_ce_hold: assert property (
		!ce_in && !global_set_reset |=> $stable(in_q_reg))
		else $error("input register changed with enable low");

	chk_delay_tap: assert property (
		cfg.dly_sel == IOC_DLY_AUTO && !cfg.quick_en |->
			tap == TAP_W'(DLY_FULL))
		else $error("default delay is not the full delay");

	chk_quick_medium: assert property (
		cfg.dly_sel == IOC_DLY_AUTO && cfg.quick_en && TWO_TAP == 1 |->
			dly_eff == IOC_DLY_MED)
		else $error("quick latch default delay is not medium");

	chk_quick_open: assert property (
		!out_eff && !global_set_reset |=> quick_q_reg == $past(dly_data))
		else $error("quick latch not transparent with clock low");

	chk_out_ff: assert property (
		out_edge && ce_out && !global_set_reset ##1 !global_set_reset
			|-> out_q_reg == $past(out_d) ##1 pad_out_reg ==
			($past(cfg.out_reg) ? $past(out_q_reg) : $past(out_d)))
		else $error("output flop did not capture or reach the pad");

	chk_float_pad: assert property (
		t_eff || (global_output_float && !extest_active) |=> pad_oe_n_reg)
		else $error("pad driven while float requested");

	chk_write_resp: assert property (
		s_write_ready |=> bvalid_reg ##1 (bvalid_reg || !$past(bvalid_reg) ||
			$past(s_axi_bready)))
		else $error("write response missing after address and data");

endmodule : ioc_cell

`default_nettype wire

// *** verif/ioc_pad_model.sv ***
// Far side of the cell: pad wire with its pull-up, and the cell clock pins.
// Assumes the bench supplies the external pad driver and clock sources.
`timescale 1ns/1ps
`default_nettype none

module ioc_pad_model
(
	input  wire logic pad_out,
	input  wire logic pad_oe_n,
	input  wire logic ext_en,
	input  wire logic ext_val,
	input  wire logic clk_src_in,
	input  wire logic clk_src_out,
	output var  logic pad_level,
	output var  logic in_clk,
	output var  logic out_clk
);

	////////////////////////////////////////////////////////////////////////
	// Cell drive wins over the bench driver whenever both are on
	always_comb
	begin
		if (!pad_oe_n)
			pad_level = pad_out;
		else if (ext_en)
			pad_level = ext_val;
		else
			pad_level = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// In and out clock pins fed straight from separate sources, clk_src_in and clk_src_out
	assign in_clk  = clk_src_in;
	assign out_clk = clk_src_out;

endmodule : ioc_pad_model
`default_nettype wire

// *** verif/io_cell_storage_elements_tb_top.sv ***
// Bench for the I/O cell: register access, pad and cell clock stimulus.
// Assumes ioc_pad_model resolves the pad wire and the cell clock pins.
`timescale 1ns/1ps
`default_nettype none

module io_cell_storage_elements_tb_top;
	import ioc_pkg::*;

	logic        sys_clk, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata, rv;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
	logic        pad_in, pad_out, pad_oe_n, in_clk_pin, out_clk_pin;
	logic        cell_clock_enable, global_set_reset, global_output_float;
	logic        extest_active, fab_out_data, fab_tristate, fab_in1, fab_in2;
	logic        ext_en, ext_val, clk_a, clk_b;
	int          fail_count, n_tests, cyc;
	ioc_stat_t   st;
	ioc_cfg_t    c;
	ioc_dly_t    ds [5] = '{IOC_DLY_AUTO, IOC_DLY_AUTO, IOC_DLY_MED,
		IOC_DLY_NONE, IOC_DLY_FULL};
	ioc_dly_t    es [5] = '{IOC_DLY_FULL, IOC_DLY_MED, IOC_DLY_MED,
		IOC_DLY_NONE, IOC_DLY_FULL};
	logic [4:0]  qs = 5'b10010;

	ioc_cell i_dut (.sys_clk(sys_clk), .resetn(resetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .pad_in(pad_in), .pad_out(pad_out),
		.pad_oe_n(pad_oe_n), .in_clk_pin(in_clk_pin),
		.out_clk_pin(out_clk_pin), .cell_clock_enable(cell_clock_enable),
		.global_set_reset(global_set_reset),
		.global_output_float(global_output_float),
		.extest_active(extest_active), .fab_out_data(fab_out_data),
		.fab_tristate(fab_tristate), .fab_in1(fab_in1), .fab_in2(fab_in2));

	ioc_pad_model i_pad (.pad_out(pad_out), .pad_oe_n(pad_oe_n),
		.ext_en(ext_en), .ext_val(ext_val), .clk_src_in(clk_a),
		.clk_src_out(clk_b), .pad_level(pad_in), .in_clk(in_clk_pin),
		.out_clk(out_clk_pin));

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// Ceiling well above the roughly 1000 cycles the sequence needs
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			fail_count++;
			give_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_ok && w_ok))
		begin
			@(posedge sys_clk);
			if (s_axi_awvalid && s_axi_awready)
				aw_ok = 1'b1;
			if (s_axi_wvalid && s_axi_wready)
				w_ok = 1'b1;
			if (aw_ok)
				s_axi_awvalid <= 1'b0;
			if (w_ok)
				s_axi_wvalid <= 1'b0;
		end
		do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
		rr = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
		rv = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd

	task automatic cfg();
		wr(4'h0, {15'h0, c});
		repeat (4) @(posedge sys_clk);
	endtask : cfg

	task automatic getst();
		rd(4'h4);
		st = ioc_stat_t'(rv[8:0]);
	endtask : getst

	// Pins: 0 pad, 1 in clk, 2 out clk, 3 data, 4 tristate, 5 enable,
	// 6 set-reset, 7 float, 8 external test, 9 pad driver on.
	// Long settle covers the pin filters plus the full input delay.
	task automatic pin(input int k, input logic v);
		@(posedge sys_clk);
		case (k)
			0: ext_val <= v;
			1: clk_a <= v;
			2: clk_b <= v;
			3: fab_out_data <= v;
			4: fab_tristate <= v;
			5: cell_clock_enable <= v;
			6: global_set_reset <= v;
			7: global_output_float <= v;
			8: extest_active <= v;
			default: ext_en <= v;
		endcase
		repeat (12) @(posedge sys_clk);
	endtask : pin

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		{resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
		{s_axi_wdata, cell_clock_enable, global_set_reset} = '0;
		{global_output_float, extest_active, fab_out_data} = '0;
		{fab_tristate, ext_en, ext_val, clk_a, clk_b} = '0;
		{fail_count, n_tests, cyc} = '0;
		s_axi_wstrb = 4'hf;
		c = '0;
		repeat (4) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rd(4'h0);
		chk(rv, 32'h0);
		chk(rr, 2'b00);
		rd(4'h8);
		chk({rv[29:0], rr}, 32'h2);
		wr(4'h8, 32'h1);
		chk(rr, 2'b10);
		wr(4'h4, 32'h1);
		chk(rr, 2'b00);
		rd(4'h0);
		chk(rv, 32'h0);
		// Output path, three-state and its polarity
		pin(3, 1'b1);
		chk(pad_oe_n, 1'b0);
		chk(pad_out, 1'b1);
		c.out_inv = 1'b1;
		cfg();
		chk(pad_out, 1'b0);
		c.t_conn = 1'b1;
		cfg();
		pin(4, 1'b1);
		chk(pad_oe_n, 1'b1);
		c.t_inv = 1'b1;
		cfg();
		chk(pad_oe_n, 1'b0);
		pin(7, 1'b1);
		chk(pad_oe_n, 1'b1);
		pin(8, 1'b1);
		chk(pad_oe_n, 1'b0);
		pin(8, 1'b0);
		pin(7, 1'b0);
		// Open drain: data tied low, signal on the three-state control
		c = '0;
		c.t_conn = 1'b1;
		cfg();
		pin(3, 1'b0);
		pin(4, 1'b0);
		chk(pad_in, 1'b0);
		pin(4, 1'b1);
		chk(pad_in, 1'b1);
		// Input flop with enable left unconnected, then connected
		pin(9, 1'b1);
		pin(0, 1'b1);
		pin(1, 1'b1);
		getst();
		chk(st.in_q, 1'b1);
		pin(0, 1'b0);
		pin(1, 1'b0);
		getst();
		chk(st.in_q, 1'b1);
		pin(1, 1'b1);
		getst();
		chk(st.in_q, 1'b0);
		c.ce_conn = 1'b1;
		c.ce_in_en = 1'b1;
		cfg();
		pin(0, 1'b1);
		pin(1, 1'b0);
		pin(1, 1'b1);
		getst();
		chk(st.in_q, 1'b0);
		pin(5, 1'b1);
		pin(1, 1'b0);
		pin(1, 1'b1);
		getst();
		chk(st.in_q, 1'b1);
		c.ce_in_en = 1'b0;
		cfg();
		pin(5, 1'b0);
		pin(0, 1'b0);
		pin(1, 1'b0);
		pin(1, 1'b1);
		getst();
		chk(st.in_q, 1'b0);
		// Inverted input clock: load on the falling pin edge
		c.in_clk_inv = 1'b1;
		cfg();
		pin(0, 1'b1);
		pin(1, 1'b0);
		getst();
		chk(st.in_q, 1'b1);
		pin(0, 1'b0);
		pin(1, 1'b1);
		getst();
		chk(st.in_q, 1'b1);
		pin(1, 1'b0);
		c.in_clk_inv = 1'b0;
		// Presets win over clock and data while held
		c.in_preset = 1'b1;
		c.out_preset = 1'b1;
		cfg();
		pin(6, 1'b1);
		pin(1, 1'b1);
		getst();
		chk({st.out_q, st.in_q}, 2'b11);
		pin(6, 1'b0);
		c.in_preset = 1'b0;
		c.out_preset = 1'b0;
		cfg();
		pin(6, 1'b1);
		pin(6, 1'b0);
		getst();
		chk({st.out_q, st.in_q}, 2'b00);
		// Latch mode: hold with in clock high or enable low, transparent with in clock low
		c.in_latch = 1'b1;
		cfg();
		pin(0, 1'b1);
		getst();
		chk(st.in_q, 1'b0);
		pin(1, 1'b0);
		getst();
		chk(st.in_q, 1'b1);
		pin(0, 1'b0);
		getst();
		chk(st.in_q, 1'b0);
		c.ce_in_en = 1'b1;
		cfg();
		pin(0, 1'b1);
		getst();
		chk(st.in_q, 1'b0);
		// Fabric paths: direct pad, then registered value
		c = '0;
		c.t_conn = 1'b1;
		cfg();
		chk({fab_in2, fab_in1}, 2'b11);
		c.fab1_reg = 1'b1;
		c.fab2_reg = 1'b1;
		cfg();
		chk({fab_in2, fab_in1}, 2'b00);
		for (int i = 0; i < 5; i++)
		begin
			c.dly_sel = ds[i];
			c.quick_en = qs[i];
			cfg();
			getst();
			chk(st.dly_eff, es[i]);
		end
		// Quick latch on the out clock, low-transparent, feeds in flop
		pin(0, 1'b0);
		getst();
		chk(st.quick_q, 1'b0);
		pin(0, 1'b1);
		getst();
		chk(st.quick_q, 1'b1);
		pin(2, 1'b1);
		pin(0, 1'b0);
		getst();
		chk(st.quick_q, 1'b1);
		pin(1, 1'b1);
		getst();
		chk(st.in_q, 1'b1);
		pin(2, 1'b0);
		getst();
		chk(st.quick_q, 1'b0);
		// Output flop on the out clock
		c = '0;
		c.out_reg = 1'b1;
		cfg();
		pin(9, 1'b0);
		pin(4, 1'b0);
		pin(3, 1'b1);
		chk(pad_out, 1'b0);
		pin(2, 1'b1);
		chk(pad_out, 1'b1);
		pin(3, 1'b0);
		pin(2, 1'b0);
		chk(pad_out, 1'b1);
		c.ce_conn = 1'b1;
		c.ce_out_en = 1'b1;
		cfg();
		pin(2, 1'b1);
		chk(pad_out, 1'b1);
		pin(5, 1'b1);
		pin(2, 1'b0);
		pin(2, 1'b1);
		chk(pad_out, 1'b0);
		c.out_clk_inv = 1'b1;
		cfg();
		pin(3, 1'b1);
		pin(2, 1'b0);
		chk(pad_out, 1'b1);
		give_verdict();
	end

endmodule : io_cell_storage_elements_tb_top
`default_nettype wire
